// ===== hw/dtor_regs.vh
// register offsets, field layout and reset values of the lane timing override bank
`ifndef DTOR_REGS_VH
`define DTOR_REGS_VH

// main map ports (8-bit address space)
`define DTOR_INDEX_PORT_ADDR   8'h6C
`define DTOR_VALUE_PORT_ADDR   8'h6D
`define DTOR_INDEX_RESET       8'h00

// indirect offsets
`define DTOR_CLK_PREP_OFS      8'h00
`define DTOR_CLK_ZERO_OFS      8'h01
`define DTOR_CLK_TRAIL_OFS     8'h02
`define DTOR_CLK_POST_OFS      8'h03
`define DTOR_DAT_PREP_OFS      8'h04
`define DTOR_DAT_ZERO_OFS      8'h05

// common layout
`define DTOR_OVR_BIT           7
`define DTOR_REG_RESET         8'h00
`define DTOR_READ_ZERO         8'h00

// output reset values, one per field width
`define DTOR_RST_W4            4'h0
`define DTOR_RST_W5            5'h00
`define DTOR_RST_W6            6'h00
`define DTOR_RST_FLAGS         6'h00
`define DTOR_RST_BIT           1'h0

// value field widths
`define DTOR_W_CLK_PREP        5
`define DTOR_W_CLK_ZERO        6
`define DTOR_W_CLK_TRAIL       4
`define DTOR_W_CLK_POST        6
`define DTOR_W_DAT_PREP        5
`define DTOR_W_DAT_ZERO        5

`endif

// ===== hw/dtor_timing_reg.v
// one override register: stored byte plus resolved timing value
`include "dtor_regs.vh"

module dtor_timing_reg #(
    parameter [7:0] OFS = 8'h00,
    parameter       FW  = 5
) (
    input  wire          core_clk,
    input  wire          rst_b,
    input  wire          clk_en,
    input  wire          wr_stb,
    input  wire [7:0]    index,
    input  wire [7:0]    wr_data,
    input  wire [FW-1:0] auto_val,
    output wire [7:0]    reg_val,
    output wire [FW-1:0] eff_val,
    output wire          override
);
    reg [7:0] store_ff;
    wire      hit;

    assign hit = (index == OFS);

    // whole byte kept, reserved bits are read/write storage
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            store_ff <= `DTOR_REG_RESET;
        end else if (clk_en && wr_stb && hit) begin
            store_ff <= wr_data;
        end
    end

    assign reg_val  = store_ff;
    assign override = store_ff[`DTOR_OVR_BIT];
    // override picks the programmed low field, else automatic value
    assign eff_val  = override ? store_ff[FW-1:0] : auto_val;
endmodule // dtor_timing_reg

// ===== hw/dtor_index_port.v
// indirect index port: holds the selected indirect offset
`include "dtor_regs.vh"

module dtor_index_port (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    input  wire       wr_stb,
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    output wire [7:0] index
);
    reg [7:0] index_ff;

    // offset latched from a write to the index port
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            index_ff <= `DTOR_INDEX_RESET;
        end else if (clk_en && wr_stb && addr == `DTOR_INDEX_PORT_ADDR) begin
            index_ff <= wr_data;
        end
    end

    assign index = index_ff;
endmodule // dtor_index_port

// ===== hw/dtor_bank.v
// lane timing override bank reached through an indirect index/value port pair
`include "dtor_regs.vh"

// Summary of operation
// - clock prepare time is automatic unless its override bit is set, then the 5-bit field.
// - clock zero time uses the 6-bit field while its override is set, else automatic.
// - clock trail time uses the 4-bit field while its override is set, else automatic.
// - clock post time uses the 6-bit field while its override is set, else automatic.
// - data prepare time uses the 5-bit field while its override is set, else automatic.
// - data zero time uses the 5-bit field while its override is set, else automatic.
// - every register, clock prepare included, reads zero after reset so timing is automatic.
// - software writes the wanted indirect offset into the index port first.
// - reads and writes of the value port then reach the selected indirect register.
module dtor_bank (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire [4:0] auto_clk_prep,
    input  wire [5:0] auto_clk_zero,
    input  wire [3:0] auto_clk_trail,
    input  wire [5:0] auto_clk_post,
    input  wire [4:0] auto_dat_prep,
    input  wire [4:0] auto_dat_zero,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    output reg  [4:0] clk_prep_time,
    output reg  [5:0] clk_zero_time,
    output reg  [3:0] clk_trail_time,
    output reg  [5:0] clk_post_time,
    output reg  [4:0] dat_prep_time,
    output reg  [4:0] dat_zero_time,
    output reg  [5:0] override_flags
);

    // port decode and the selected indirect offset
    wire       index_sel;
    wire       value_sel;
    wire [7:0] index;
    wire       val_wr;

    // stored bytes of the six override registers, in offset order
    wire [7:0] r0;
    wire [7:0] r1;
    wire [7:0] r2;
    wire [7:0] r3;
    wire [7:0] r4;
    wire [7:0] r5;

    // resolved timing values, each at its own field width
    wire [4:0] e0;
    wire [5:0] e1;
    wire [3:0] e2;
    wire [5:0] e3;
    wire [4:0] e4;
    wire [4:0] e5;

    // override bits, bit 7 of each stored byte
    wire       o0;
    wire       o1;
    wire       o2;
    wire       o3;
    wire       o4;
    wire       o5;

    // read data ahead of the response flop
    reg  [7:0] nxt_rdata;

    // main-map address hits the index port
    function f_is_index_port;
        input [7:0] addr;
        begin
            f_is_index_port = (addr == `DTOR_INDEX_PORT_ADDR);
        end
    endfunction

    // main-map address hits the value port
    function f_is_value_port;
        input [7:0] addr;
        begin
            f_is_value_port = (addr == `DTOR_VALUE_PORT_ADDR);
        end
    endfunction

    // stored byte of the selected offset; offsets past the six registers
    // belong to other logic, so they read back as zero here
    function [7:0] f_pick_indirect;
        input [7:0] sel;
        input [7:0] b0;
        input [7:0] b1;
        input [7:0] b2;
        input [7:0] b3;
        input [7:0] b4;
        input [7:0] b5;
        begin
            case (sel)
                `DTOR_CLK_PREP_OFS:  f_pick_indirect = b0;
                `DTOR_CLK_ZERO_OFS:  f_pick_indirect = b1;
                `DTOR_CLK_TRAIL_OFS: f_pick_indirect = b2;
                `DTOR_CLK_POST_OFS:  f_pick_indirect = b3;
                `DTOR_DAT_PREP_OFS:  f_pick_indirect = b4;
                `DTOR_DAT_ZERO_OFS:  f_pick_indirect = b5;
                default:             f_pick_indirect = `DTOR_READ_ZERO;
            endcase
        end
    endfunction

    // value port hit shared by the write strobe and the read mux; the index port hit feeds only the read mux
    assign index_sel = f_is_index_port(reg_addr);
    assign value_sel = f_is_value_port(reg_addr);

    // value port writes go to whichever register the index selects
    assign val_wr = reg_wr && value_sel;

    // index port: the offset stays until software writes a new one,
    // so a run of accesses to one register needs a single index write
    dtor_index_port u_index (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (reg_wr),
        .addr     (reg_addr),
        .wr_data  (reg_wdata),
        .index    (index)
    );

    // clock lane prepare, 5-bit field at offset 0; reset leaves it
    // automatic, so the lanes come up on hardware-chosen timing
    dtor_timing_reg #(
        .OFS (`DTOR_CLK_PREP_OFS),
        .FW  (`DTOR_W_CLK_PREP)
    ) u_clk_prep (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_clk_prep),
        .reg_val  (r0),
        .eff_val  (e0),
        .override (o0)
    );

    // clock lane zero, 6-bit field at offset 1; bit 6 is plain
    // storage and never reaches the timing output
    dtor_timing_reg #(
        .OFS (`DTOR_CLK_ZERO_OFS),
        .FW  (`DTOR_W_CLK_ZERO)
    ) u_clk_zero (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_clk_zero),
        .reg_val  (r1),
        .eff_val  (e1),
        .override (o1)
    );

    // clock lane trail, 4-bit field at offset 2; the narrowest field,
    // bits 6:4 only store what software wrote
    dtor_timing_reg #(
        .OFS (`DTOR_CLK_TRAIL_OFS),
        .FW  (`DTOR_W_CLK_TRAIL)
    ) u_clk_trail (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_clk_trail),
        .reg_val  (r2),
        .eff_val  (e2),
        .override (o2)
    );

    // clock lane post, 6-bit field at offset 3; the value is taken
    // as written, range limits are left to software
    dtor_timing_reg #(
        .OFS (`DTOR_CLK_POST_OFS),
        .FW  (`DTOR_W_CLK_POST)
    ) u_clk_post (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_clk_post),
        .reg_val  (r3),
        .eff_val  (e3),
        .override (o3)
    );

    // data lane prepare, 5-bit field at offset 4; shares the write
    // strobe with the others, the offset match picks the target
    dtor_timing_reg #(
        .OFS (`DTOR_DAT_PREP_OFS),
        .FW  (`DTOR_W_DAT_PREP)
    ) u_dat_prep (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_dat_prep),
        .reg_val  (r4),
        .eff_val  (e4),
        .override (o4)
    );

    // data lane zero, 5-bit field at offset 5; last register of the
    // bank, higher offsets fall through to the zero read
    dtor_timing_reg #(
        .OFS (`DTOR_DAT_ZERO_OFS),
        .FW  (`DTOR_W_DAT_ZERO)
    ) u_dat_zero (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .wr_stb   (val_wr),
        .index    (index),
        .wr_data  (reg_wdata),
        .auto_val (auto_dat_zero),
        .reg_val  (r5),
        .eff_val  (e5),
        .override (o5)
    );

    // read mux; the index port reads back the current offset so
    // software can save and restore it around an access
    always @* begin
        nxt_rdata = `DTOR_READ_ZERO;
        if (index_sel) begin
            nxt_rdata = index;
        end else if (value_sel) begin
            nxt_rdata = f_pick_indirect(index, r0, r1, r2, r3, r4, r5);
        end
    end

    // read valid is a one-cycle pulse after each taken read
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rvalid <= `DTOR_RST_BIT;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
        end
    end

    // read data held until the next read, so a slow master may take it late
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `DTOR_READ_ZERO;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end

    // clock lane timing from flops; the cycle of lag behind a write is
    // harmless as long as timing is only changed while the lanes idle
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_prep_time  <= `DTOR_RST_W5;
            clk_zero_time  <= `DTOR_RST_W6;
            clk_trail_time <= `DTOR_RST_W4;
            clk_post_time  <= `DTOR_RST_W6;
        end else if (clk_en) begin
            clk_prep_time  <= e0;
            clk_zero_time  <= e1;
            clk_trail_time <= e2;
            clk_post_time  <= e3;
        end
    end

    // data lane timing from flops, same lag as the clock lane
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dat_prep_time  <= `DTOR_RST_W5;
            dat_zero_time  <= `DTOR_RST_W5;
        end else if (clk_en) begin
            dat_prep_time  <= e4;
            dat_zero_time  <= e5;
        end
    end

    // override flags, bit 0 for offset 0, one cycle behind the bytes
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            override_flags <= `DTOR_RST_FLAGS;
        end else if (clk_en) begin
            override_flags <= {o5, o4, o3, o2, o1, o0};
        end
    end
endmodule // dtor_bank

// ===== dv/dtor_bank_sva.sv
// port-level checker of the lane timing override bank
`include "dtor_regs.vh"
module dtor_bank_sva (
    input wire       core_clk, rst_b, clk_en, reg_rd, reg_rvalid,
    input wire [7:0] reg_addr, reg_rdata,
    input wire [4:0] auto_clk_prep, auto_dat_prep, auto_dat_zero,
    input wire [4:0] clk_prep_time, dat_prep_time, dat_zero_time,
    input wire [5:0] auto_clk_zero, auto_clk_post, clk_zero_time, clk_post_time, override_flags,
    input wire [3:0] auto_clk_trail, clk_trail_time
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_rvalid_after_rd: assert property (clk_en && reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_no_rd: assert property (clk_en && !reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    a_unmapped_zero: assert property (clk_en && reg_rd && reg_addr != `DTOR_INDEX_PORT_ADDR
        && reg_addr != `DTOR_VALUE_PORT_ADDR |=> reg_rdata == 8'h00) else $error("bad read");
    a_cp_auto: assert property (clk_en ##1 !override_flags[0]
        |-> clk_prep_time == $past(auto_clk_prep)) else $error("clock prepare not auto");
    a_cz_auto: assert property (clk_en ##1 !override_flags[1]
        |-> clk_zero_time == $past(auto_clk_zero)) else $error("clock zero not auto");
    a_ct_auto: assert property (clk_en ##1 !override_flags[2]
        |-> clk_trail_time == $past(auto_clk_trail)) else $error("clock trail not auto");
    a_cpo_auto: assert property (clk_en ##1 !override_flags[3]
        |-> clk_post_time == $past(auto_clk_post)) else $error("clock post not auto");
    a_dp_auto: assert property (clk_en ##1 !override_flags[4]
        |-> dat_prep_time == $past(auto_dat_prep)) else $error("data prepare not auto");
    a_dz_auto: assert property (clk_en ##1 !override_flags[5]
        |-> dat_zero_time == $past(auto_dat_zero)) else $error("data zero not auto");
    c_read: cover property (reg_rvalid);
    c_all_ovr: cover property (&override_flags);
    c_unmapped: cover property (reg_rd && reg_addr == 8'h6E);
endmodule // dtor_bank_sva
bind dtor_bank dtor_bank_sva u_sva (.*);

// ===== dv/tb_dtor_bank.sv
// self-checking bench of the lane timing override bank
`include "dtor_regs.vh"
module tb_dtor_bank;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m [0:5];
    logic [30:0] auto_v = 31'h5A5A_1234, t_v;
    logic [5:0]  override_flags;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    dtor_bank uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .auto_clk_prep(auto_v[30:26]), .auto_clk_zero(auto_v[25:20]),
        .auto_clk_trail(auto_v[19:16]), .auto_clk_post(auto_v[15:10]),
        .auto_dat_prep(auto_v[9:5]), .auto_dat_zero(auto_v[4:0]), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .clk_prep_time(t_v[30:26]), .clk_zero_time(t_v[25:20]),
        .clk_trail_time(t_v[19:16]), .clk_post_time(t_v[15:10]), .dat_prep_time(t_v[9:5]),
        .dat_zero_time(t_v[4:0]), .override_flags(override_flags));
    initial forever #50 core_clk = ~core_clk;
    // hang guard: the whole run needs about 130 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk({reg_rvalid, reg_rdata}, {1'b1, exp});
    endtask
    // outputs settle one edge after the register write lands
    task automatic chk_out();
        repeat (2) @(negedge core_clk);
        chk(t_v, {m[0][7] ? m[0][4:0] : auto_v[30:26], m[1][7] ? m[1][5:0] : auto_v[25:20],
            m[2][7] ? m[2][3:0] : auto_v[19:16], m[3][7] ? m[3][5:0] : auto_v[15:10],
            m[4][7] ? m[4][4:0] : auto_v[9:5], m[5][7] ? m[5][4:0] : auto_v[4:0]});
        chk(override_flags, {m[5][7], m[4][7], m[3][7], m[2][7], m[1][7], m[0][7]});
    endtask
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            m[i] = 8'h00;
            wr(`DTOR_INDEX_PORT_ADDR, i);
            rd(`DTOR_VALUE_PORT_ADDR, 8'h00);
        end
        chk_out();
        rd(`DTOR_INDEX_PORT_ADDR, 8'h05);
    endtask
    // reserved bits ride along; auto change must not leak through an override
    task automatic t_override();
        for (int i = 0; i < 6; i++) begin
            m[i] = 8'hFF - 8'h11 * i;
            wr(`DTOR_INDEX_PORT_ADDR, i);
            wr(`DTOR_VALUE_PORT_ADDR, m[i]);
            rd(`DTOR_VALUE_PORT_ADDR, m[i]);
            chk_out();
        end
        @(posedge core_clk);
        auto_v <= ~auto_v;
        chk_out();
        for (int i = 5; i >= 0; i--) begin
            m[i][7] = 1'b0;
            wr(`DTOR_INDEX_PORT_ADDR, i);
            wr(`DTOR_VALUE_PORT_ADDR, m[i]);
            chk_out();
        end
    endtask
    task automatic t_reserved();
        // reserved offset 6 is only read, never written; unmapped port 6E is written and read
        wr(`DTOR_INDEX_PORT_ADDR, 8'h06);
        rd(`DTOR_VALUE_PORT_ADDR, 8'h00);
        wr(8'h6E, 8'h00);
        rd(8'h6E, 8'h00);
        rd(`DTOR_INDEX_PORT_ADDR, 8'h06);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(`DTOR_INDEX_PORT_ADDR, 8'h00);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd(`DTOR_INDEX_PORT_ADDR, 8'h06);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_override();
        t_reserved();
        give_verdict();
    end
endmodule // tb_dtor_bank
